/* File: hw/subbank_pkg.sv */
// Package with the register map, sub-address limits and storage layout of the indirect register banks.
package subbank_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int RAM_AW = 7;
    localparam int RAM_DEPTH = 128;

    // Directly mapped data-memory locations.
    localparam logic [ADDR_W-1:0] SP0_PTR_OFFS   = 16'h0038;
    localparam logic [ADDR_W-1:0] SP0_DATA_OFFS  = 16'h0039;
    localparam logic [ADDR_W-1:0] SP1_PTR_OFFS   = 16'h0048;
    localparam logic [ADDR_W-1:0] SP1_DATA_OFFS  = 16'h0049;
    localparam logic [ADDR_W-1:0] DMA_PREC_OFFS  = 16'h0054;
    localparam logic [ADDR_W-1:0] DMA_PTR_OFFS   = 16'h0055;
    localparam logic [ADDR_W-1:0] DMA_STEP_OFFS  = 16'h0056;
    localparam logic [ADDR_W-1:0] DMA_PLAIN_OFFS = 16'h0057;

    // Serial-port subbank sub-addresses.
    localparam logic [DATA_W-1:0] SUB_PORT_CTRL1  = 16'h0000;
    localparam logic [DATA_W-1:0] SUB_RX_CTRL1    = 16'h0002;
    localparam logic [DATA_W-1:0] SUB_TX_CTRL1    = 16'h0004;
    localparam logic [DATA_W-1:0] SUB_SRATE1      = 16'h0006;
    localparam logic [DATA_W-1:0] SUB_MCHAN1      = 16'h0008;
    localparam logic [DATA_W-1:0] SUB_CHAN_EN_RXA = 16'h000a;
    localparam logic [DATA_W-1:0] SUB_PIN_CTRL    = 16'h000e;
    localparam logic [DATA_W-1:0] SP_SUB_LAST     = SUB_PIN_CTRL;

    // DMA subbank sub-addresses.
    localparam logic [DATA_W-1:0] SUB_CHAN_STRIDE = 16'h0005;
    localparam logic [DATA_W-1:0] SUB_CHAN5_FIRST = 16'h0019;
    localparam logic [DATA_W-1:0] SUB_CHAN5_LAST  = 16'h001d;
    localparam logic [DATA_W-1:0] SUB_SRC_PAGE    = 16'h001e;
    localparam logic [DATA_W-1:0] SUB_DST_PAGE    = 16'h001f;
    localparam logic [DATA_W-1:0] SUB_ELEM_IDX0   = 16'h0020;
    localparam logic [DATA_W-1:0] SUB_FRAME_IDX0  = 16'h0022;
    localparam logic [DATA_W-1:0] SUB_GLOB_SRC    = 16'h0024;
    localparam logic [DATA_W-1:0] SUB_GLOB_FRAME  = 16'h0027;
    localparam logic [DATA_W-1:0] DMA_SUB_LAST    = SUB_GLOB_FRAME;

    // Storage bases of each subbank inside the shared word memory.
    localparam logic [RAM_AW-1:0] SP0_BASE = 7'h00;
    localparam logic [RAM_AW-1:0] SP1_BASE = 7'h10;
    localparam logic [RAM_AW-1:0] DMA_BASE = 7'h20;

    localparam logic [DATA_W-1:0] PTR_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] PREC_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] PTR_STEP   = 16'h0001;
    localparam int READ_LATENCY = 2;

endpackage : subbank_pkg

/* File: hw/subbank_mem_if.sv */
// Interface carrying the single-port access between the bank decoder and its word memory.
`timescale 1ns/1ps
interface subbank_mem_if #(
    parameter int AW = 7,
    parameter int DW = 16
);
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface : subbank_mem_if

/* File: hw/subbank_ram.sv */
// Word memory that stores every subbank register, with registered read data.
`timescale 1ns/1ps
module subbank_ram #(
    parameter int AW    = 7,
    parameter int DW    = 16,
    parameter int DEPTH = 128
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    subbank_mem_if.mem port
);
    logic [DW-1:0] store [DEPTH];
    logic [DW-1:0] rdata;
    logic [DW-1:0] next_rdata;

    always_comb begin
        next_rdata = store[port.addr];
    end

    // The array itself has no reset; only the read register does.
    always_ff @(posedge mclk_i) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign port.rdata = rdata;

endmodule : subbank_ram

/* File: hw/subbank_regs.sv */
// Indirect register access for two serial-port subbanks and the DMA subbank.
//
// Operation
// - Serial-port control registers are reached by writing a sub-address to the pointer, then using the data port.
// - Serial port 0 has its data port at 39h and port 1 at 49h, reading or writing the selected register.
// - Serial sub-addresses 00h to 05h select port control 1/2, receive control 1/2 and transmit control 1/2.
// - Sub-addresses 06h to 0Eh select sample-rate 1/2, multichannel 1/2, four channel enables and pin control.
// - The DMA priority-and-enable control register is mapped directly; the other DMA registers only via the subbank.
// - Software loads the DMA pointer first and the DMA data-port access goes to the register it selects.
// - The plain DMA data port at 57h accesses the selected register and leaves the pointer as it is.
// - The stepping DMA data port at 56h accesses the selected register and then adds one to the pointer.
// - Each of six DMA channels owns five sub-addresses from five times its number; channel 5 spans 19h to 1Dh.
// - DMA sub-addresses 1Eh and 1Fh hold the source and destination program pages shared by all channels.
// - DMA sub-addresses 20h to 23h hold element index 0/1 and frame index 0/1.
// - DMA sub-addresses 24h to 27h hold the global source, destination, count and frame reload values.
// - The serial-port pointers sit at 38h and 48h, just below their data ports.
// - The DMA pointer sits at 55h next to the two DMA data ports.
`timescale 1ns/1ps
module subbank_regs
    import subbank_pkg::*;
#(
    parameter int RAM_DEPTH_P = RAM_DEPTH
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              rd_i,
    input  wire logic              wr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o,
    output logic                   rvalid_o,
    output logic      [DATA_W-1:0] dma_priority_enable_ctrl_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [RAM_AW-1:0] bank_addr(input logic [RAM_AW-1:0] base,
                                                    input logic [DATA_W-1:0] ptr);
        return RAM_AW'(base + ptr[RAM_AW-1:0]);
    endfunction : bank_addr

    function automatic logic sub_defined(input logic [DATA_W-1:0] ptr,
                                         input logic [DATA_W-1:0] last);
        return ptr <= last;
    endfunction : sub_defined

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    logic [DATA_W-1:0] serial_port_pointer_reg0;
    logic [DATA_W-1:0] serial_port_pointer_reg1;
    logic [DATA_W-1:0] dma_pointer_reg;
    logic [DATA_W-1:0] dma_priority_enable_ctrl;
    logic              s1_valid;
    logic              s1_from_mem;
    logic [DATA_W-1:0] s1_direct;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;

    logic [DATA_W-1:0] next_serial_port_pointer_reg0;
    logic [DATA_W-1:0] next_serial_port_pointer_reg1;
    logic [DATA_W-1:0] next_dma_pointer_reg;
    logic [DATA_W-1:0] next_dma_priority_enable_ctrl;
    logic              next_s1_valid;
    logic              next_s1_from_mem;
    logic [DATA_W-1:0] next_s1_direct;
    logic [DATA_W-1:0] next_rdata;
    logic              next_rvalid;

    logic              access;
    logic              rd_take;
    logic              mem_sel;
    logic [RAM_AW-1:0] mem_addr;
    logic [DATA_W-1:0] direct_val;

    subbank_mem_if #(.AW(RAM_AW), .DW(DATA_W)) mem_bus ();

    subbank_ram #(
        .AW    (RAM_AW),
        .DW    (DATA_W),
        .DEPTH (RAM_DEPTH_P)
    ) subbank_ram_inst (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .port    (mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and pointer update.

    // A write wins when read and write strobes arrive together.
    assign access  = rd_i | wr_i;
    assign rd_take = rd_i & ~wr_i;

    always_comb begin
        next_serial_port_pointer_reg0 = serial_port_pointer_reg0;
        next_serial_port_pointer_reg1 = serial_port_pointer_reg1;
        next_dma_pointer_reg          = dma_pointer_reg;
        next_dma_priority_enable_ctrl = dma_priority_enable_ctrl;
        mem_sel                       = 1'b0;
        mem_addr                      = '0;
        direct_val                    = '0;
        case (addr_i)
            SP0_PTR_OFFS: begin
                direct_val = serial_port_pointer_reg0;
                if (wr_i) begin
                    next_serial_port_pointer_reg0 = wdata_i;
                end
            end
            SP1_PTR_OFFS: begin
                direct_val = serial_port_pointer_reg1;
                if (wr_i) begin
                    next_serial_port_pointer_reg1 = wdata_i;
                end
            end
            SP0_DATA_OFFS: begin
                // Sub-addresses 00h to 0Eh map one to one onto the stored control words.
                mem_sel  = sub_defined(serial_port_pointer_reg0, SP_SUB_LAST);
                mem_addr = bank_addr(SP0_BASE, serial_port_pointer_reg0);
            end
            SP1_DATA_OFFS: begin
                mem_sel  = sub_defined(serial_port_pointer_reg1, SP_SUB_LAST);
                mem_addr = bank_addr(SP1_BASE, serial_port_pointer_reg1);
            end
            DMA_PREC_OFFS: begin
                direct_val = dma_priority_enable_ctrl;
                if (wr_i) begin
                    next_dma_priority_enable_ctrl = wdata_i;
                end
            end
            DMA_PTR_OFFS: begin
                direct_val = dma_pointer_reg;
                if (wr_i) begin
                    next_dma_pointer_reg = wdata_i;
                end
            end
            DMA_STEP_OFFS: begin
                // Channel n at 5n..5n+4, then pages, index and reload words up to 27h.
                mem_sel  = sub_defined(dma_pointer_reg, DMA_SUB_LAST);
                mem_addr = bank_addr(DMA_BASE, dma_pointer_reg);
                if (access) begin
                    next_dma_pointer_reg = dma_pointer_reg + PTR_STEP;
                end
            end
            DMA_PLAIN_OFFS: begin
                mem_sel  = sub_defined(dma_pointer_reg, DMA_SUB_LAST);
                mem_addr = bank_addr(DMA_BASE, dma_pointer_reg);
            end
            default: begin
                direct_val = '0;
            end
        endcase
    end

    assign mem_bus.we    = wr_i & mem_sel;
    assign mem_bus.addr  = mem_addr;
    assign mem_bus.wdata = wdata_i;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_port_pointer_reg0 <= PTR_RESET;
            serial_port_pointer_reg1 <= PTR_RESET;
            dma_pointer_reg          <= PTR_RESET;
            dma_priority_enable_ctrl <= PREC_RESET;
        end else begin
            serial_port_pointer_reg0 <= next_serial_port_pointer_reg0;
            serial_port_pointer_reg1 <= next_serial_port_pointer_reg1;
            dma_pointer_reg          <= next_dma_pointer_reg;
            dma_priority_enable_ctrl <= next_dma_priority_enable_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read return: stage one waits for the memory, stage two drives the port.

    always_comb begin
        next_s1_valid    = rd_take;
        next_s1_from_mem = rd_take & mem_sel;
        next_s1_direct   = rd_take ? direct_val : '0;
        next_rvalid      = s1_valid;
        next_rdata       = '0;
        if (s1_valid) begin
            next_rdata = s1_from_mem ? mem_bus.rdata : s1_direct;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_valid    <= 1'b0;
            s1_from_mem <= 1'b0;
            s1_direct   <= '0;
            rvalid      <= 1'b0;
            rdata       <= '0;
        end else begin
            s1_valid    <= next_s1_valid;
            s1_from_mem <= next_s1_from_mem;
            s1_direct   <= next_s1_direct;
            rvalid      <= next_rvalid;
            rdata       <= next_rdata;
        end
    end

    assign rdata_o                    = rdata;
    assign rvalid_o                   = rvalid;
    assign dma_priority_enable_ctrl_o = dma_priority_enable_ctrl;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence step_access_s;
        access && addr_i == DMA_STEP_OFFS;
    endsequence

    sequence plain_access_s;
        access && addr_i == DMA_PLAIN_OFFS;
    endsequence

    sequence read_taken_s;
        rd_take;
    endsequence

    sequence sp0_bad_read_s;
        rd_take && addr_i == SP0_DATA_OFFS && serial_port_pointer_reg0 > SP_SUB_LAST;
    endsequence

    sequence sp1_bad_read_s;
        rd_take && addr_i == SP1_DATA_OFFS && serial_port_pointer_reg1 > SP_SUB_LAST;
    endsequence

    sequence dma_bad_read_s;
        rd_take && addr_i == DMA_PLAIN_OFFS && dma_pointer_reg > DMA_SUB_LAST;
    endsequence

    dma_step_ptr_a: assert property (step_access_s |=> dma_pointer_reg == $past(dma_pointer_reg) + PTR_STEP)
        else $error("stepping port did not advance the pointer by one");

    dma_plain_hold_a: assert property (plain_access_s |=> $stable(dma_pointer_reg))
        else $error("plain port changed the pointer");

    read_return_time_a: assert property (read_taken_s |-> ##1 s1_valid ##1 rvalid_o)
        else $error("read data not returned two cycles after the request");

    sp0_ptr_load_a: assert property (wr_i && addr_i == SP0_PTR_OFFS |=>
                                     serial_port_pointer_reg0 == $past(wdata_i))
        else $error("serial port 0 pointer not loaded");

    sp0_undef_zero_a: assert property (sp0_bad_read_s |-> ##2 rvalid_o && rdata_o == '0)
        else $error("undefined serial sub-address did not read zero");

    dma_undef_zero_a: assert property (dma_bad_read_s |-> ##2 rvalid_o && rdata_o == '0)
        else $error("undefined DMA sub-address did not read zero");

    prec_direct_a: assert property (wr_i && addr_i == DMA_PREC_OFFS |=>
                                    dma_priority_enable_ctrl_o == $past(wdata_i))
        else $error("priority and enable control not written directly");

    dma_write_route_a: assert property (wr_i && addr_i == DMA_STEP_OFFS &&
                                        dma_pointer_reg <= DMA_SUB_LAST |->
                                        mem_bus.we && mem_bus.addr == RAM_AW'(DMA_BASE + dma_pointer_reg[6:0]))
        else $error("DMA write not routed to the selected sub-address");

    sp1_write_route_a: assert property (wr_i && addr_i == SP1_DATA_OFFS &&
                                        serial_port_pointer_reg1 <= SP_SUB_LAST |->
                                        mem_bus.we &&
                                        mem_bus.addr == RAM_AW'(SP1_BASE + serial_port_pointer_reg1[6:0]))
        else $error("serial port 1 write not routed to the selected register");

    undef_write_drop_a: assert property (wr_i && addr_i == SP0_DATA_OFFS &&
                                         serial_port_pointer_reg0 > SP_SUB_LAST |-> !mem_bus.we)
        else $error("write to undefined sub-address reached storage");

    sp1_ptr_load_a: assert property (wr_i && addr_i == SP1_PTR_OFFS |=>
                                     serial_port_pointer_reg1 == $past(wdata_i))
        else $error("serial port 1 pointer not loaded");

    dma_ptr_load_a: assert property (wr_i && addr_i == DMA_PTR_OFFS |=>
                                     dma_pointer_reg == $past(wdata_i))
        else $error("DMA pointer not loaded");

    sp1_undef_zero_a: assert property (sp1_bad_read_s |-> ##2 rvalid_o && rdata_o == '0)
        else $error("undefined serial port 1 sub-address did not read zero");

    dma_ptr_read_a: assert property (rd_take && addr_i == DMA_PTR_OFFS |->
                                     ##2 rdata_o == $past(dma_pointer_reg, 2))
        else $error("DMA pointer read back wrong");

    prec_hold_a: assert property (!(wr_i && addr_i == DMA_PREC_OFFS) |=>
                                  $stable(dma_priority_enable_ctrl_o))
        else $error("priority and enable control changed without a write");

    rdata_idle_zero_a: assert property (!rvalid_o |-> rdata_o == '0)
        else $error("read data not zero outside a read return");

    plain_write_route_a: assert property (wr_i && addr_i == DMA_PLAIN_OFFS &&
                                          dma_pointer_reg <= DMA_SUB_LAST |->
                                          mem_bus.we && mem_bus.addr == RAM_AW'(DMA_BASE + dma_pointer_reg[6:0]))
        else $error("plain DMA write not routed to the selected sub-address");

endmodule : subbank_regs

/* File: tb/core_access_model.sv */
// Behavioural processor core that issues data-memory reads and writes to the register block.
`timescale 1ns/1ps
module core_access_model
    import subbank_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    input  wire logic              rvalid_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   rd_o,
    output logic                   wr_o,
    output logic      [DATA_W-1:0] wdata_o
);
    initial begin
        addr_o  = 16'hffff;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        wdata_o = 16'hffff;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic write_word(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        @(posedge mclk_i);
        addr_o  <= addr;
        wdata_o <= data;
        wr_o    <= 1'b1;
        @(posedge mclk_i);
        // Released lines show inverted values so that a late sample cannot match by chance.
        addr_o  <= ~addr;
        wdata_o <= ~data;
        wr_o    <= 1'b0;
    endtask : write_word

    task automatic read_word(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
        int n;
        @(posedge mclk_i);
        addr_o <= addr;
        rd_o   <= 1'b1;
        @(posedge mclk_i);
        addr_o <= ~addr;
        rd_o   <= 1'b0;
        data = 'x;
        for (n = 0; n < READ_LATENCY + 2; n++) begin
            @(posedge mclk_i);
            #1;
            if (rvalid_i === 1'b1) begin
                data = rdata_i;
                break;
            end
        end
    endtask : read_word
endmodule : core_access_model

/* File: tb/tb_subbank_indirect_register_access.sv */
// Self-checking testbench of the indirect register banks.
`timescale 1ns/1ps
module tb_subbank_indirect_register_access;
    import subbank_pkg::*;

    localparam int CYCLE_LIMIT = 5000;

    logic              mclk_i;
    logic              rst_n_i;
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic [DATA_W-1:0] prec;
    int                bad_count;
    int                check_count;
    int                cycle_count;
    int                b;
    int                s;

    subbank_regs subbank_regs_inst (
        .mclk_i                     (mclk_i),
        .rst_n_i                    (rst_n_i),
        .addr_i                     (addr),
        .rd_i                       (rd),
        .wr_i                       (wr),
        .wdata_i                    (wdata),
        .rdata_o                    (rdata),
        .rvalid_o                   (rvalid),
        .dma_priority_enable_ctrl_o (prec)
    );

    core_access_model core_access_model_inst (
        .mclk_i   (mclk_i),
        .rdata_i  (rdata),
        .rvalid_i (rvalid),
        .addr_o   (addr),
        .rd_o     (rd),
        .wr_o     (wr),
        .wdata_o  (wdata)
    );

    initial mclk_i = 1'b0;
    always #5 mclk_i = ~mclk_i;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [DATA_W-1:0] pattern(input int bank, input int sub);
        return 16'(((bank + 1) << 12) | (sub << 6) | sub);
    endfunction : pattern

    function automatic logic [ADDR_W-1:0] sp_ptr(input int bank);
        return (bank == 1) ? SP1_PTR_OFFS : SP0_PTR_OFFS;
    endfunction : sp_ptr

    function automatic logic [ADDR_W-1:0] sp_data(input int bank);
        return (bank == 1) ? SP1_DATA_OFFS : SP0_DATA_OFFS;
    endfunction : sp_data

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t word mismatch got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        core_access_model_inst.write_word(a, d);
    endtask : write_reg

    task automatic expect_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] got;
        core_access_model_inst.read_word(a, got);
        check_word(got, exp);
    endtask : expect_read

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk_i) begin
        cycle_count++;
        if (cycle_count == CYCLE_LIMIT) begin
            bad_count++;
            $display("[ERR] %0t run did not finish in time", $time);
            stop_test();
        end
    end

    initial begin
        rst_n_i = 1'b0;
        bad_count = 0;
        check_count = 0;
        cycle_count = 0;
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        check_word(prec, PREC_RESET);
        expect_read(SP0_PTR_OFFS, PTR_RESET);
        expect_read(SP1_PTR_OFFS, PTR_RESET);
        expect_read(DMA_PTR_OFFS, PTR_RESET);
        // Fill both serial subbanks with distinct words.
        for (b = 0; b < 2; b++) begin
            for (s = 0; s <= int'(SP_SUB_LAST); s++) begin
                write_reg(sp_ptr(b), 16'(s));
                write_reg(sp_data(b), pattern(b, s));
            end
        end
        // A write beyond the last serial sub-address must not land in the other port.
        write_reg(SP0_PTR_OFFS, 16'h0010);
        write_reg(SP0_DATA_OFFS, 16'hdead);
        expect_read(SP0_DATA_OFFS, 16'h0000);
        write_reg(SP1_PTR_OFFS, 16'h000f);
        expect_read(SP1_DATA_OFFS, 16'h0000);
        for (b = 0; b < 2; b++) begin
            for (s = 0; s <= int'(SP_SUB_LAST); s++) begin
                write_reg(sp_ptr(b), 16'(s));
                expect_read(sp_ptr(b), 16'(s));
                expect_read(sp_data(b), pattern(b, s));
            end
        end
        // Fill the whole DMA subbank through the stepping port.
        write_reg(DMA_PTR_OFFS, PTR_RESET);
        for (s = 0; s <= int'(DMA_SUB_LAST); s++)
            write_reg(DMA_STEP_OFFS, pattern(2, s));
        expect_read(DMA_PTR_OFFS, 16'h0028);
        write_reg(DMA_STEP_OFFS, 16'hbeef);
        expect_read(DMA_PTR_OFFS, 16'h0029);
        expect_read(DMA_PLAIN_OFFS, 16'h0000);
        for (s = 0; s <= int'(DMA_SUB_LAST); s++) begin
            write_reg(DMA_PTR_OFFS, 16'(s));
            expect_read(DMA_PLAIN_OFFS, pattern(2, s));
            expect_read(DMA_PTR_OFFS, 16'(s));
        end
        // Stepping reads walk through the five words of channel 5.
        write_reg(DMA_PTR_OFFS, SUB_CHAN5_FIRST);
        for (s = int'(SUB_CHAN5_FIRST); s <= int'(SUB_CHAN5_LAST); s++)
            expect_read(DMA_STEP_OFFS, pattern(2, s));
        expect_read(DMA_PTR_OFFS, SUB_SRC_PAGE);
        write_reg(DMA_PLAIN_OFFS, 16'h5a5a);
        expect_read(DMA_PTR_OFFS, SUB_SRC_PAGE);
        expect_read(DMA_PLAIN_OFFS, 16'h5a5a);
        expect_read(SP0_DATA_OFFS, pattern(0, int'(SP_SUB_LAST)));
        // Direct priority register and an unmapped location.
        write_reg(DMA_PREC_OFFS, 16'hc3a5);
        #1;
        check_word(prec, 16'hc3a5);
        expect_read(DMA_PREC_OFFS, 16'hc3a5);
        write_reg(16'h003a, 16'h1234);
        expect_read(16'h003a, 16'h0000);
        stop_test();
    end
endmodule : tb_subbank_indirect_register_access
